// ---- common/tpt_pkg.sv ----
/*
 * Package for the transmit PTP timestamp port: operation codes, field widths,
 * lane count, offset limits and per-lane correction constants.
 * Assumes both ends run on one TX clock with a synchronous active-high reset.
 */
package tpt_pkg;

    // ------------------------------------------------------------------
    // Widths
    // ------------------------------------------------------------------
    localparam int TS_W = 80;
    localparam int TAG_W = 16;
    localparam int OFS_W = 16;
    localparam int LANE_W = 5;
    localparam logic [LANE_W-1:0] NUM_LANES = 5'h14;
    localparam logic [OFS_W-1:0] MAX_FRAME_BYTES = 16'h4000;
    localparam logic [OFS_W-1:0] TC_CHK_SPAN = 16'h0022;

    // ------------------------------------------------------------------
    // Tag FIFO between frame start and capture plane
    // ------------------------------------------------------------------
    localparam int TAGQ_DEPTH = 4;
    localparam int TAGQ_AW = 2;
    localparam logic [TAGQ_AW:0] TAGQ_CNT_FULL = 3'h4;

    // Per-lane correction step in timer units, applied in one-step only
    localparam logic [TS_W-1:0] LANE_ADJ_STEP = 80'h0000_0000_0000_0001_0000;

    // Pipeline delay from tag write to capture plane, in cycles; capture falls four cycles after frame start
    localparam logic [3:0] CAPTURE_DLY = 4'h3;

    typedef enum logic [1:0] {
        TPT_OP_NONE = 2'b00,
        TPT_OP_ONE_STEP = 2'b01,
        TPT_OP_TWO_STEP = 2'b10,
        TPT_OP_RSVD = 2'b11
    } tpt_op_t;

endpackage

// ---- common/tpt_if.sv ----
/*
 * Interface joining the client end and the MAC end of the TX PTP port.
 * Assumes a single TX clock supplied by the testbench.
 */
`timescale 1ns/10ps
`default_nettype none
interface tpt_if import tpt_pkg::*; (
    input wire logic CLK
);
    logic sop;
    logic [1:0] op;
    logic [TAG_W-1:0] tag;
    logic upd_chksum;
    logic [OFS_W-1:0] chksum_offset;
    logic [OFS_W-1:0] tstamp_offset;
    logic [TS_W-1:0] systimer;
    logic ts_valid;
    logic [TS_W-1:0] ts;
    logic [TAG_W-1:0] ts_tag;
    logic [LANE_W-1:0] ts_lane;
    logic wr_err;
    logic rd_err;

    modport mac (
        input sop, op, tag, upd_chksum, chksum_offset, tstamp_offset, systimer,
        output ts_valid, ts, ts_tag, ts_lane, wr_err, rd_err
    );
    modport client (
        output sop, op, tag, upd_chksum, chksum_offset, tstamp_offset, systimer,
        input ts_valid, ts, ts_tag, ts_lane, wr_err, rd_err
    );
endinterface
`default_nettype wire

// ---- design/tpt_mac_end.sv ----
/*
 * MAC end of the TX PTP timestamp port. Takes per-frame controls at frame
 * start, queues the tag, captures the timer when the frame start reaches the
 * capture plane and returns timestamp, tag and lane. One-step insertion
 * requests (offsets, checksum flag) are latched for the frame datapath.
 * At most four stamps wait at once; a frame start beyond that loses its stamp.
 * Assumes frame start pulses arrive on CLK from the transmit datapath.
 */
`timescale 1ns/10ps
`default_nettype none

// Contract
// [RULE1] Op 00 none, 01 one-step, 10 two-step
// [RULE2] Two-step: capture timestamp, frame unaltered
// [RULE3] Echo 16-bit tag for timestamped frames
// [RULE4] Valid marks a presented timestamp
// [RULE5] Return 5-bit lane of frame start
// [RULE6] 80-bit capture-plane time, timer format
// [RULE7] Checksum-update bit used for one-step only
// [RULE8] Checksum offset from destination address byte
// [RULE9] Timestamp offset from destination address byte
// [RULE10] Transparent clock uses offset for correction
// [RULE11] Client gives even offsets only
// [RULE12] TC: timestamp offset within checksum plus 34
// [RULE13] Offsets span frames up to 16K
// [RULE14] Lane adjust corrects one-step timestamps only
// [RULE15] Tag write error sticky until reset
// [RULE16] Tag read error sticky until reset
// [RULE17] Client drives 80-bit timer on TX clock
// [RULE18] One valid pulse per frame, in order
module tpt_mac_end import tpt_pkg::*; (
    input wire logic CLK,
    input wire logic SYS_RST,
    tpt_if.mac LINK,
    input wire logic TC_MODE,
    input wire logic LANE_ADJUST,
    input wire logic [LANE_W-1:0] SOP_LANE,
    output logic INSERT_REQ,
    output logic INSERT_CHKSUM,
    output logic INSERT_TC,
    output logic [OFS_W-1:0] INSERT_TS_OFS,
    output logic [OFS_W-1:0] INSERT_CHK_OFS,
    output logic OFS_ERR
);

    // ------------------------------------------------------------------
    // Frame start decode
    // ------------------------------------------------------------------
    wire logic is_one = LINK.sop && (LINK.op == TPT_OP_ONE_STEP); // RULE1
    wire logic is_two = LINK.sop && (LINK.op == TPT_OP_TWO_STEP); // RULE1
    wire logic stamp_req = is_one || is_two; // RULE2
    wire logic chk_on = is_one && LINK.upd_chksum; // RULE7

    // ------------------------------------------------------------------
    // Offset checks: odd or past a jumbo frame cannot be placed
    // ------------------------------------------------------------------
    function automatic logic ofs_bad(input var logic [OFS_W-1:0] ofs);
        return ofs[0] || (ofs >= MAX_FRAME_BYTES);
    endfunction
    wire logic ts_ofs_bad = ofs_bad(LINK.tstamp_offset); // RULE11 RULE13
    wire logic chk_ofs_bad = chk_on && ofs_bad(LINK.chksum_offset); // RULE11 RULE8
    // Correction field must stay within reach of the checksum fix-up
    wire logic [OFS_W:0] chk_lim = {1'b0, LINK.chksum_offset} + {1'b0, TC_CHK_SPAN};
    wire logic tc_span_bad = chk_on && TC_MODE && ({1'b0, LINK.tstamp_offset} > chk_lim); // RULE12

    // ------------------------------------------------------------------
    // Tag queue, flop storage
    // ------------------------------------------------------------------
    logic [TAG_W-1:0] q_tag_ff [TAGQ_DEPTH];
    logic [LANE_W-1:0] q_lane_ff [TAGQ_DEPTH];
    logic q_one_ff [TAGQ_DEPTH];
    logic [TAGQ_AW-1:0] wp_ff, rp_ff;
    logic [TAGQ_AW:0] cnt_ff;
    logic [3:0] dly_ff [TAGQ_DEPTH];
    logic wr_err_ff, rd_err_ff;

    wire logic q_full = (cnt_ff == TAGQ_CNT_FULL);
    wire logic q_empty = (cnt_ff == '0);
    // A full queue drops the tag rather than stall the frame; the loss is flagged
    wire logic do_wr = stamp_req && !q_full;
    // Head reaches capture plane after a fixed datapath delay
    wire logic head_due = !q_empty && (dly_ff[rp_ff] == CAPTURE_DLY);
    wire logic do_rd = head_due;

    always_ff @(posedge CLK) begin
        if (SYS_RST) begin
            wp_ff <= '0;
            rp_ff <= '0;
            cnt_ff <= '0;
        end else begin
            if (do_wr) begin
                wp_ff <= wp_ff + 1'b1;
            end
            if (do_rd) begin
                rp_ff <= rp_ff + 1'b1;
            end
            cnt_ff <= cnt_ff + {2'b00, do_wr} - {2'b00, do_rd};
        end
    end

    genvar gi;
    generate
        for (gi = 0; gi < TAGQ_DEPTH; gi++) begin : g_slot
            always_ff @(posedge CLK) begin
                if (SYS_RST) begin
                    q_tag_ff[gi] <= '0;
                    q_lane_ff[gi] <= '0;
                    q_one_ff[gi] <= 1'b0;
                    dly_ff[gi] <= '0;
                end else if (do_wr && (wp_ff == TAGQ_AW'(gi))) begin
                    q_tag_ff[gi] <= LINK.tag; // RULE3
                    // Stored raw so that a lane out of range is caught on retrieval
                    q_lane_ff[gi] <= SOP_LANE; // RULE5
                    q_one_ff[gi] <= is_one;
                    dly_ff[gi] <= '0;
                end else if (dly_ff[gi] != CAPTURE_DLY) begin
                    dly_ff[gi] <= dly_ff[gi] + 4'h1;
                end
            end
        end
    endgenerate

    // ------------------------------------------------------------------
    // Errors: sticky until reset, reset wins
    // ------------------------------------------------------------------
    // A lane outside the PCS range means the slot read back corrupt; the
    // stamp is still returned so that later frames keep their order
    wire logic rd_fault = do_rd && (q_lane_ff[rp_ff] >= NUM_LANES); // RULE16
    always_ff @(posedge CLK) begin
        if (SYS_RST) begin
            wr_err_ff <= 1'b0;
            rd_err_ff <= 1'b0;
        end else begin
            // A tag dropped on a full queue leaves its frame without a stamp
            wr_err_ff <= wr_err_ff || (stamp_req && q_full); // RULE15
            rd_err_ff <= rd_err_ff || rd_fault; // RULE16
        end
    end

    // ------------------------------------------------------------------
    // Timestamp return
    // ------------------------------------------------------------------
    wire logic [LANE_W-1:0] head_lane = q_lane_ff[rp_ff];
    wire logic [TS_W-1:0] lane_corr = LANE_ADJ_STEP * TS_W'(head_lane);
    // Correction uses the lane recorded with the frame, not the current one
    wire logic use_adj = LANE_ADJUST && q_one_ff[rp_ff]; // RULE14
    wire logic [TS_W-1:0] cap_ts = use_adj ? (LINK.systimer + lane_corr) : LINK.systimer; // RULE6

    logic vld_ff;
    logic [TS_W-1:0] ts_ff;
    logic [TAG_W-1:0] tag_ff;
    logic [LANE_W-1:0] lane_ff;
    always_ff @(posedge CLK) begin
        if (SYS_RST) begin
            vld_ff <= 1'b0;
            ts_ff <= '0;
            tag_ff <= '0;
            lane_ff <= '0;
        end else begin
            // One-cycle pulse; the data fields hold until the next stamp
            vld_ff <= do_rd; // RULE4 RULE18
            if (do_rd) begin
                ts_ff <= cap_ts; // RULE2
                tag_ff <= q_tag_ff[rp_ff]; // RULE3
                lane_ff <= head_lane; // RULE5
            end
        end
    end

    // ------------------------------------------------------------------
    // One-step insertion request to frame datapath
    // ------------------------------------------------------------------
    logic ins_ff, ins_chk_ff, ins_tc_ff, ofs_err_ff;
    logic [OFS_W-1:0] ins_ts_ofs_ff, ins_chk_ofs_ff;
    always_ff @(posedge CLK) begin
        if (SYS_RST) begin
            ins_ff <= 1'b0;
            ins_chk_ff <= 1'b0;
            ins_tc_ff <= 1'b0;
            ins_ts_ofs_ff <= '0;
            ins_chk_ofs_ff <= '0;
            ofs_err_ff <= 1'b0;
        end else begin
            // Bad offsets drop the insertion so the frame passes unmodified
            ins_ff <= is_one && !ts_ofs_bad && !chk_ofs_bad && !tc_span_bad; // RULE9
            if (is_one) begin
                ins_chk_ff <= chk_on; // RULE7
                ins_tc_ff <= TC_MODE; // RULE10
                ins_ts_ofs_ff <= LINK.tstamp_offset; // RULE9 RULE10
                ins_chk_ofs_ff <= chk_on ? LINK.chksum_offset : '0; // RULE8
            end
            ofs_err_ff <= ofs_err_ff || (is_one && (ts_ofs_bad || chk_ofs_bad || tc_span_bad));
        end
    end

    assign LINK.ts_valid = vld_ff;
    assign LINK.ts = ts_ff;
    assign LINK.ts_tag = tag_ff;
    assign LINK.ts_lane = lane_ff;
    assign LINK.wr_err = wr_err_ff;
    assign LINK.rd_err = rd_err_ff;
    assign INSERT_REQ = ins_ff;
    assign INSERT_CHKSUM = ins_chk_ff;
    assign INSERT_TC = ins_tc_ff;
    assign INSERT_TS_OFS = ins_ts_ofs_ff;
    assign INSERT_CHK_OFS = ins_chk_ofs_ff;
    assign OFS_ERR = ofs_err_ff;

endmodule
`default_nettype wire

// ---- design/tpt_client_end.sv ----
/*
 * Client end of the TX PTP timestamp port. Runs the 80-bit system timer,
 * registers per-frame requests onto the link and captures returned stamps.
 * Assumes the user side issues one request per cycle at most.
 */
`timescale 1ns/10ps
`default_nettype none
module tpt_client_end import tpt_pkg::*; (
    input wire logic CLK,
    input wire logic SYS_RST,
    tpt_if.client LINK,
    input wire logic TC_MODE,
    input wire logic [TS_W-1:0] TIMER_STEP,
    input wire logic REQ,
    input wire logic [1:0] REQ_OP,
    input wire logic [TAG_W-1:0] REQ_TAG,
    input wire logic REQ_CHKSUM,
    input wire logic [OFS_W-1:0] REQ_CHK_OFS,
    input wire logic [OFS_W-1:0] REQ_TS_OFS,
    output logic RET_VALID,
    output logic [TS_W-1:0] RET_TS,
    output logic [TAG_W-1:0] RET_TAG,
    output logic [LANE_W-1:0] RET_LANE,
    output logic ERR
);

    // ------------------------------------------------------------------
    // Request shaping
    // ------------------------------------------------------------------
    wire logic op_rsvd = (REQ_OP == TPT_OP_RSVD); // RULE1
    wire logic [1:0] op_ok = op_rsvd ? TPT_OP_NONE : REQ_OP; // RULE1
    wire logic one = (op_ok == TPT_OP_ONE_STEP);
    // Force even offsets; low bit is not supported downstream
    wire logic [OFS_W-1:0] chk_even = {REQ_CHK_OFS[OFS_W-1:1], 1'b0}; // RULE11
    wire logic [OFS_W-1:0] ts_even = {REQ_TS_OFS[OFS_W-1:1], 1'b0}; // RULE11
    wire logic [OFS_W:0] ts_lim = {1'b0, chk_even} + {1'b0, TC_CHK_SPAN};
    wire logic clamp = TC_MODE && REQ_CHKSUM && ({1'b0, ts_even} > ts_lim);
    wire logic [OFS_W-1:0] ts_sel = clamp ? ts_lim[OFS_W-1:0] : ts_even; // RULE12

    logic sop_ff, chk_ff, err_ff;
    logic [1:0] op_ff;
    logic [TAG_W-1:0] tag_ff;
    logic [OFS_W-1:0] chk_ofs_ff, ts_ofs_ff;
    logic [TS_W-1:0] timer_ff;
    always_ff @(posedge CLK) begin
        if (SYS_RST) begin
            sop_ff <= 1'b0;
            op_ff <= TPT_OP_NONE;
            tag_ff <= '0;
            chk_ff <= 1'b0;
            chk_ofs_ff <= '0;
            ts_ofs_ff <= '0;
            timer_ff <= '0;
        end else begin
            sop_ff <= REQ;
            timer_ff <= timer_ff + TIMER_STEP; // RULE17
            if (REQ) begin
                op_ff <= op_ok;
                tag_ff <= REQ_TAG;
                chk_ff <= one && REQ_CHKSUM; // RULE7
                chk_ofs_ff <= chk_even; // RULE8
                ts_ofs_ff <= ts_sel; // RULE9
            end
        end
    end

    // ------------------------------------------------------------------
    // Return capture
    // ------------------------------------------------------------------
    logic vld_ff;
    logic [TS_W-1:0] ts_ff;
    logic [TAG_W-1:0] rtag_ff;
    logic [LANE_W-1:0] lane_ff;
    always_ff @(posedge CLK) begin
        if (SYS_RST) begin
            vld_ff <= 1'b0;
            ts_ff <= '0;
            rtag_ff <= '0;
            lane_ff <= '0;
            err_ff <= 1'b0;
        end else begin
            vld_ff <= LINK.ts_valid;
            if (LINK.ts_valid) begin
                ts_ff <= LINK.ts;
                rtag_ff <= LINK.ts_tag;
                lane_ff <= LINK.ts_lane;
            end
            err_ff <= LINK.wr_err || LINK.rd_err;
        end
    end

    assign LINK.sop = sop_ff;
    assign LINK.op = op_ff;
    assign LINK.tag = tag_ff;
    assign LINK.upd_chksum = chk_ff;
    assign LINK.chksum_offset = chk_ofs_ff;
    assign LINK.tstamp_offset = ts_ofs_ff;
    assign LINK.systimer = timer_ff;
    assign RET_VALID = vld_ff;
    assign RET_TS = ts_ff;
    assign RET_TAG = rtag_ff;
    assign RET_LANE = lane_ff;
    assign ERR = err_ff;

endmodule
`default_nettype wire

// ---- dv/tpt_link_checker.sv ----
/*
 * Concurrent checks on the link between the client end and the MAC end.
 * Assumes one clock and a synchronous active-high reset.
 */
`timescale 1ns/10ps
`default_nettype none
module tpt_link_checker import tpt_pkg::*; (
    input wire logic CLK,
    input wire logic SYS_RST,
    input wire logic sop,
    input wire logic [1:0] op,
    input wire logic [TAG_W-1:0] tag,
    input wire logic [OFS_W-1:0] chksum_offset,
    input wire logic [OFS_W-1:0] tstamp_offset,
    input wire logic ts_valid,
    input wire logic [TS_W-1:0] ts,
    input wire logic [TAG_W-1:0] ts_tag,
    input wire logic [LANE_W-1:0] ts_lane,
    input wire logic wr_err,
    input wire logic rd_err
);
    default clocking cb @(posedge CLK);
    endclocking
    default disable iff (SYS_RST);
    // ------------------------------------------------------------------
    // Stamp return
    // ------------------------------------------------------------------
    // A dropped stamp must show up as an error instead
    property p_stamp_lat;
        sop && (op == 2'b01 || op == 2'b10) |-> ##5 (ts_valid || wr_err || rd_err);
    endproperty
    a_stamp_lat: assert property (p_stamp_lat) else $error("stamp missing after frame start");
    property p_no_stamp;
        sop && (op == 2'b00 || op == 2'b11) |-> ##5 !ts_valid;
    endproperty
    a_no_stamp: assert property (p_no_stamp) else $error("stamp for frame without operation");
    property p_tag_echo;
        ts_valid |-> $past(sop, 5) && ts_tag == $past(tag, 5);
    endproperty
    a_tag_echo: assert property (p_tag_echo) else $error("returned tag does not match frame");
    property p_hold;
        !ts_valid && !$past(SYS_RST) |-> $stable(ts) && $stable(ts_tag) && $stable(ts_lane);
    endproperty
    a_hold: assert property (p_hold) else $error("returned stamp changed without valid");
    property p_lane_err;
        ts_valid && ts_lane >= 5'h14 |-> ##[0:1] rd_err;
    endproperty
    a_lane_err: assert property (p_lane_err) else $error("bad lane without read error");
    // ------------------------------------------------------------------
    // Errors and requests
    // ------------------------------------------------------------------
    property p_wr_sticky;
        wr_err |=> wr_err;
    endproperty
    a_wr_sticky: assert property (p_wr_sticky) else $error("write error cleared without reset");
    property p_rst_clear;
        disable iff (1'b0) SYS_RST |=> !wr_err && !rd_err && !ts_valid;
    endproperty
    a_rst_clear: assert property (p_rst_clear) else $error("errors not cleared by reset");
    property p_ofs_even;
        sop |-> !chksum_offset[0] && !tstamp_offset[0];
    endproperty
    a_ofs_even: assert property (p_ofs_even) else $error("odd offset on link");
    c_two_step: cover property (sop && op == 2'b10 ##5 ts_valid);
    c_wr_err: cover property ($rose(wr_err));
    c_back_to_back: cover property (ts_valid ##1 ts_valid);
endmodule
`default_nettype wire

// ---- dv/tx_ptp_timestamp_port_tb.sv ----
/*
 * Self-checking bench: client end and MAC end joined by the link interface.
 * Assumes package, interface and checker are compiled first.
 */
`timescale 1ns/10ps
`default_nettype none
`define CHK(nm, e, g) begin check_count++; if ((g) !== (e)) begin num_errors++; \
    $display("[FAIL] %s exp=%0h got=%0h", nm, e, g); end end
module tx_ptp_timestamp_port_tb import tpt_pkg::*;;
    typedef struct packed {
        logic [1:0] op; logic [TAG_W-1:0] tag; logic upd; logic [OFS_W-1:0] chk, tso;
        logic [LANE_W-1:0] lane; logic vld, ins; logic [OFS_W-1:0] ets;
    } tpt_row_t;
    logic clk, rst, tc_mode, lane_adj, req, req_chk, ins_req, ins_chk, ins_tc, ofs_err, ret_valid, err;
    logic [1:0] req_op;
    logic [TAG_W-1:0] req_tag, ret_tag;
    logic [OFS_W-1:0] req_chk_ofs, req_ts_ofs, ins_ts_ofs, ins_chk_ofs, g_tso, g_cho;
    logic [LANE_W-1:0] req_lane, sop_lane, ret_lane;
    logic [TS_W-1:0] step, ret_ts;
    logic [TS_W-1:0] got_ts[$];
    logic [TAG_W-1:0] got_tag[$];
    logic [LANE_W-1:0] got_lane[$];
    logic [3:0] n_ins;
    logic g_chk, g_tc;
    int num_errors = 0;
    int check_count = 0;
    tpt_row_t rows [6];
    tpt_if link_if (.CLK(clk));
    tpt_client_end tpt_client_end_i (.CLK(clk), .SYS_RST(rst), .LINK(link_if), .TC_MODE(tc_mode),
        .TIMER_STEP(step), .REQ(req), .REQ_OP(req_op), .REQ_TAG(req_tag), .REQ_CHKSUM(req_chk),
        .REQ_CHK_OFS(req_chk_ofs), .REQ_TS_OFS(req_ts_ofs), .RET_VALID(ret_valid), .RET_TS(ret_ts),
        .RET_TAG(ret_tag), .RET_LANE(ret_lane), .ERR(err));
    tpt_mac_end tpt_mac_end_i (.CLK(clk), .SYS_RST(rst), .LINK(link_if), .TC_MODE(tc_mode),
        .LANE_ADJUST(lane_adj), .SOP_LANE(sop_lane), .INSERT_REQ(ins_req), .INSERT_CHKSUM(ins_chk),
        .INSERT_TC(ins_tc), .INSERT_TS_OFS(ins_ts_ofs), .INSERT_CHK_OFS(ins_chk_ofs), .OFS_ERR(ofs_err));
    tpt_link_checker tpt_link_checker_i (.CLK(clk), .SYS_RST(rst), .sop(link_if.sop), .op(link_if.op),
        .tag(link_if.tag), .chksum_offset(link_if.chksum_offset), .tstamp_offset(link_if.tstamp_offset),
        .ts_valid(link_if.ts_valid), .ts(link_if.ts), .ts_tag(link_if.ts_tag), .ts_lane(link_if.ts_lane),
        .wr_err(link_if.wr_err), .rd_err(link_if.rd_err));
    // ------------------------------------------------------------------
    // Tasks
    // ------------------------------------------------------------------
    // Lane follows its request by one cycle, lining up with the frame start
    task automatic send(input tpt_row_t r);
        sop_lane = req_lane;
        req_lane = r.lane;
        {req_op, req_tag, req_chk, req_chk_ofs, req_ts_ofs} = {r.op, r.tag, r.upd, r.chk, r.tso};
        req = 1'b1;
        @(posedge clk);
        #1;
    endtask
    task automatic stop();
        sop_lane = req_lane;
        req = 1'b0;
    endtask
    task automatic observe(input int cyc);
        got_ts.delete();
        got_tag.delete();
        got_lane.delete();
        n_ins = 4'h0;
        repeat (cyc) begin
            @(posedge clk);
            #1;
            if (ret_valid === 1'b1) begin
                got_ts.push_back(ret_ts);
                got_tag.push_back(ret_tag);
                got_lane.push_back(ret_lane);
            end
            if (ins_req === 1'b1) begin
                n_ins++;
                {g_tso, g_cho, g_chk, g_tc} = {ins_ts_ofs, ins_chk_ofs, ins_chk, ins_tc};
            end
        end
    endtask
    task automatic report_and_stop();
        $display("checks %0d mismatches %0d", check_count, num_errors);
        if (num_errors == 0 && check_count > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask
    // ------------------------------------------------------------------
    // Clock, watchdog, sequence
    // ------------------------------------------------------------------
    initial begin
        clk = 1'b0;
        forever #10 clk = ~clk;
    end
    initial begin
        repeat (3000) @(posedge clk);
        num_errors++;
        report_and_stop();
    end
    initial begin
        {rst, tc_mode, lane_adj, step} = {3'b100, 80'h8};
        {req, req_chk, req_op, req_tag, req_chk_ofs, req_ts_ofs, req_lane, sop_lane} = '0;
        rows[0] = '{2'h0, 16'h1111, 1'b0, 16'h0000, 16'h0000, 5'h00, 1'b0, 1'b0, 16'h0000};
        rows[1] = '{2'h1, 16'hA5A5, 1'b1, 16'h0028, 16'h002C, 5'h0D, 1'b1, 1'b1, 16'h002C};
        rows[2] = '{2'h2, 16'h5A5A, 1'b1, 16'h0028, 16'h002C, 5'h07, 1'b1, 1'b0, 16'h0000};
        rows[3] = '{2'h3, 16'h3333, 1'b0, 16'h0000, 16'h0000, 5'h00, 1'b0, 1'b0, 16'h0000};
        rows[4] = '{2'h1, 16'h0F0F, 1'b0, 16'h0000, 16'h3FFE, 5'h13, 1'b1, 1'b1, 16'h3FFE};
        rows[5] = '{2'h1, 16'hF0F0, 1'b0, 16'h0000, 16'h0031, 5'h00, 1'b1, 1'b1, 16'h0030};
        repeat (6) @(posedge clk);
        #1;
        rst = 1'b0;
        `CHK("error at start", 1'b0, err)
        `CHK("timer at start", 80'h0, link_if.systimer)
        foreach (rows[i]) begin
            send(rows[i]);
            stop();
            observe(8);
            `CHK("stamp count", rows[i].vld, got_ts.size())
            if (rows[i].vld) begin
                `CHK("tag", rows[i].tag, got_tag[0])
                `CHK("lane", rows[i].lane, got_lane[0])
            end
            `CHK("insert count", rows[i].ins, n_ins)
            if (rows[i].ins) begin
                `CHK("ts offset", rows[i].ets, g_tso)
                `CHK("chksum flag", rows[i].upd, g_chk)
                if (rows[i].upd) `CHK("chk offset", rows[i].chk, g_cho)
            end
            $display("row %0d done", i);
        end
        lane_adj = 1'b1;
        send('{2'h2, 16'h0001, 1'b0, 16'h0000, 16'h0000, 5'h02, 1'b1, 1'b0, 16'h0000});
        send('{2'h1, 16'h0002, 1'b0, 16'h0000, 16'h0020, 5'h03, 1'b1, 1'b1, 16'h0020});
        stop();
        observe(10);
        `CHK("pair count", 2, got_ts.size())
        `CHK("pair order", 32'h0001_0002, {got_tag[0], got_tag[1]})
        `CHK("ts spacing", step + 3 * LANE_ADJ_STEP, got_ts[1] - got_ts[0])
        {lane_adj, tc_mode} = 2'b01;
        $display("lane adjust test done");
        send('{2'h1, 16'h0003, 1'b1, 16'h0010, 16'h0040, 5'h01, 1'b1, 1'b1, 16'h0032});
        stop();
        observe(8);
        `CHK("tc insert count", 1, n_ins)
        `CHK("tc flag", 1'b1, g_tc)
        `CHK("tc offset", 16'h0032, g_tso)
        tc_mode = 1'b0;
        $display("transparent clock test done");
        repeat (8) send('{2'h2, 16'h00C0, 1'b0, 16'h0000, 16'h0000, 5'h04, 1'b1, 1'b0, 16'h0000});
        send('{2'h2, 16'h00D0, 1'b0, 16'h0000, 16'h0000, 5'h15, 1'b1, 1'b0, 16'h0000});
        send('{2'h1, 16'h00E0, 1'b0, 16'h0000, 16'h4000, 5'h00, 1'b1, 1'b0, 16'h0000});
        stop();
        observe(14);
        `CHK("write error", 1'b1, link_if.wr_err)
        `CHK("read error", 1'b1, link_if.rd_err)
        `CHK("offset error", 1'b1, ofs_err)
        `CHK("combined error", 1'b1, err)
        rst = 1'b1;
        @(posedge clk);
        #1;
        rst = 1'b0;
        `CHK("write error reset", 1'b0, link_if.wr_err)
        `CHK("read error reset", 1'b0, link_if.rd_err)
        repeat (2) @(posedge clk);
        #1;
        `CHK("valid after reset", 1'b0, link_if.ts_valid)
        `CHK("error after reset", 1'b0, err)
        $display("error and reset test done");
        report_and_stop();
    end
endmodule
`default_nettype wire
